/* File: logic/vrref_core.sv */
/*
  Reference code, load-line select, voltage-change slewing and current report.
  All outputs are registered; the reference is a code of 6.25mV per step and
  the slope output is in tenths of the base slope.
  Assumes register writes arrive as one-cycle strobes on the core clock and
  that pin inputs are asynchronous and synchronised here. Sample, packet and
  target inputs come from logic on the core clock and are used directly.
*/
// Summary of operation
// - Reference is target times divider ratio over 128; zero ratio passes target.
// - Reference truncated down to whole 6.25mV steps.
// - Select bit clear takes slope code from packet bits 24..22.
// - Select bit set takes slope code from config bits 11..9.
// - Code decodes to 0, 0.6 .. 1.8 times base slope.
// - Slew one 12.5mV per (count+3) ticks of 50ns.
// - Target from serial, management or parallel source, up or down.
// - Serial mode changes act only after platform power good.
// - Management and parallel changes act only after output settled.
// - Current sampled, scaled and offset; may under-report.
// - Host gain gives readback at 0.25A per bit.
// - Cpu gain gives 8-bit telemetry code, saturating at FFh.
// - Current reported on telemetry and readback register.
// - Phase shedding uses reported current when enabled.
// - Droop current is 5/32 of summed sense signal.
// - One 8-bit reference code, 6.25mV steps, up to 1.55V; zero ratio passes target unclamped up to FFh.
// - Serial upward change done sends a done notice.
`timescale 1ns/1ns
module vrref_core #(
  parameter int unsigned IW = 12
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_ff,
  input  wire logic [1:0]  vid_mode,
  input  wire logic [7:0]  serial_target,
  input  wire logic        serial_pkt_valid,
  input  wire logic [24:0] serial_packet,
  input  wire logic [7:0]  pmbus_target,
  input  wire logic        pmbus_target_wr,
  input  wire logic [7:0]  parallel_target,
  input  wire logic        platform_power_good,
  input  wire logic        phase_shed_enable,
  input  wire logic [7:0]  shed_threshold,
  input  wire logic [IW-1:0] total_current_monitor_pin_sample,
  input  wire logic        total_current_monitor_pin_sample_valid,
  input  wire logic [15:0] total_current_monitor_pin_offset,
  input  wire logic [IW-1:0] current_sum_node,
  output logic      [7:0]  ref_code_ff,
  output logic      [4:0]  slope_tenths_ff,
  output logic      [7:0]  telemetry_code_ff,
  output logic             voltage_change_done_notice_ff,
  output logic             phase_shed_ff,
  output logic             settled_ff,
  output logic      [IW-1:0] droop_current_ff
);
  localparam int unsigned MODE_SERIAL   = 0;
  localparam int unsigned MODE_PMBUS    = 1;

  logic [15:0] div_ratio_ff;
  logic [15:0] ramp_ff;
  logic [15:0] cpu_gain_ff;
  logic [15:0] host_gain_ff;
  logic [15:0] ll_cfg_ff;
  logic [15:0] iout_ff;
  logic [2:0]  pkt_slope_ff;
  logic        pg_s1_ff;
  logic        pg_s2_ff;
  logic [7:0]  target_ff;
  logic [7:0]  nxt_target;
  logic [7:0]  scaled_code;
  logic [23:0] prod;
  localparam int unsigned SLEW_CNT_W_L = vrref_pkg::SLEW_CNT_W + 1;
  // One slew step is 12.5mV, two reference codes
  localparam logic [7:0]  STEP_CODES   = 8'h02;
  localparam logic [23:0] TELE_FULL    = 24'h0000FF;

  logic [3:0]              tick_ff;
  logic [SLEW_CNT_W_L-1:0] interval_ff;
  logic                    up_ramp_ff;
  logic                    tick_end;
  logic                    interval_end;
  logic                    at_target;
  logic [31:0]             host_prod;
  logic [31:0]             cpu_prod;
  logic [IW+7:0]           droop_prod;
  logic [23:0]             host_amps;
  logic [23:0]             offset_amps;

  // Product of a current sample and an 8.8 gain word
  function automatic logic [31:0] gain_mul(input logic [IW-1:0] sample,
                                           input logic [15:0]   gain);
    gain_mul = 32'(sample) * 32'(gain);
  endfunction

  // One slew step toward the goal, landing on it without overshoot
  function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                             input logic [7:0] goal);
    if (goal > cur) begin
      step_toward = (goal - cur > STEP_CODES) ? cur + STEP_CODES : goal;
    end else begin
      step_toward = (cur - goal > STEP_CODES) ? cur - STEP_CODES : goal;
    end
  endfunction

  // Write strobe aimed at one register index
  function automatic logic reg_hit(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] idx);
    reg_hit = wr && (addr == idx);
  endfunction

  // Registers written by index; readback register has no write path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_ratio_ff <= vrref_pkg::DIV_RST;
    end else if (reg_hit(reg_wr, reg_addr, vrref_pkg::REG_DIV_RATIO)) begin
      div_ratio_ff <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ramp_ff <= vrref_pkg::RAMP_RST;
    end else if (reg_hit(reg_wr, reg_addr, vrref_pkg::REG_RAMP_TIME)) begin
      ramp_ff <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_gain_ff <= vrref_pkg::GAIN_RST;
    end else if (reg_hit(reg_wr, reg_addr, vrref_pkg::REG_CPU_GAIN)) begin
      cpu_gain_ff <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_gain_ff <= vrref_pkg::GAIN_RST;
    end else if (reg_hit(reg_wr, reg_addr, vrref_pkg::REG_HOST_GAIN)) begin
      host_gain_ff <= reg_wdata;
    end
  end

  // Slope select changes reach the slope output two cycles later; reset loads LL_RST
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ll_cfg_ff <= vrref_pkg::LL_RST;
    end else if (reg_hit(reg_wr, reg_addr, vrref_pkg::REG_LL_CONFIG)) begin
      ll_cfg_ff <= reg_wdata;
    end
  end

  // Read data registered; address must stand one cycle before use

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_ff <= 16'h0000;
    end else begin
      unique case (reg_addr)
        vrref_pkg::REG_DIV_RATIO: reg_rdata_ff <= div_ratio_ff;
        vrref_pkg::REG_RAMP_TIME: reg_rdata_ff <= ramp_ff;
        vrref_pkg::REG_IOUT_READ: reg_rdata_ff <= iout_ff;
        vrref_pkg::REG_CPU_GAIN:  reg_rdata_ff <= cpu_gain_ff;
        vrref_pkg::REG_HOST_GAIN: reg_rdata_ff <= host_gain_ff;
        vrref_pkg::REG_LL_CONFIG: reg_rdata_ff <= ll_cfg_ff;
        default:                  reg_rdata_ff <= 16'h0000;
      endcase
    end
  end

  // Power good is a pin: two flops before use
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pg_s1_ff <= 1'b0;
      pg_s2_ff <= 1'b0;
    end else begin
      pg_s1_ff <= platform_power_good;
      pg_s2_ff <= pg_s1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pkt_slope_ff <= 3'h0;
    end else if (serial_pkt_valid) begin
      pkt_slope_ff <= serial_packet[vrref_pkg::PKT_LL_LSB +: 3];
    end
  end

  // slope follows selector and source continuously
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slope_tenths_ff <= 5'h00;
    end else if (ll_cfg_ff[vrref_pkg::LL_SEL_BIT]) begin
      slope_tenths_ff <= vrref_pkg::slope_tenths(ll_cfg_ff[vrref_pkg::LL_CODE_LSB +: 3]);
    end else begin
      slope_tenths_ff <= vrref_pkg::slope_tenths(pkt_slope_ff);
    end
  end

  always_comb begin
    nxt_target = target_ff;
    if (vid_mode == 2'(MODE_SERIAL)) begin
      // serial changes wait for power good
      if (serial_pkt_valid && pg_s2_ff) begin
        nxt_target = serial_target;
      end
    end else if (settled_ff) begin
      if (vid_mode == 2'(MODE_PMBUS)) begin
        if (pmbus_target_wr) begin
          nxt_target = pmbus_target;
        end
      end else begin
        nxt_target = parallel_target;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      target_ff <= 8'h00;
    end else begin
      target_ff <= nxt_target;
    end
  end

  always_comb begin
    prod = 24'(target_ff) * 24'(div_ratio_ff);
    if (div_ratio_ff == 16'h0000) begin
      scaled_code = target_ff;
    end else if (prod[23:vrref_pkg::DIV_SHIFT] > 17'(vrref_pkg::CODE_MAX)) begin
      scaled_code = vrref_pkg::CODE_MAX;
    end else begin
      scaled_code = prod[vrref_pkg::DIV_SHIFT +: 8];
    end
  end

  // 50ns tick prescaler; free running so slew phase is not tied to writes
  assign tick_end = (tick_ff == 4'(vrref_pkg::SLEW_TICK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (srst || tick_end) begin
      tick_ff <= 4'h0;
    end else begin
      tick_ff <= tick_ff + 4'h1;
    end
  end

  // interval of count plus three ticks
  assign interval_end = (interval_ff >= SLEW_CNT_W_L'(ramp_ff[vrref_pkg::SLEW_CNT_W-1:0])
                                        + SLEW_CNT_W_L'(vrref_pkg::SLEW_EXTRA - 1));
  assign at_target    = (ref_code_ff == scaled_code);

  // step and stop on target
  // Interval restarts at each landing, so a new change waits a full interval
  always_ff @(posedge core_clk) begin
    if (srst) begin
      interval_ff <= '0;
      ref_code_ff <= 8'h00;
      settled_ff  <= 1'b0;
      up_ramp_ff  <= 1'b0;
      voltage_change_done_notice_ff <= 1'b0;
    end else begin
      voltage_change_done_notice_ff <= 1'b0;
      settled_ff <= at_target;
      if (at_target) begin
        interval_ff <= '0;
        // upward change done in serial mode
        if (up_ramp_ff && vid_mode == 2'(MODE_SERIAL)) begin
          voltage_change_done_notice_ff <= 1'b1;
        end
        up_ramp_ff <= 1'b0;
      end else if (tick_end) begin
        if (interval_end) begin
          interval_ff <= '0;
          if (scaled_code > ref_code_ff) begin
            up_ramp_ff <= 1'b1;
          end
          ref_code_ff <= step_toward(ref_code_ff, scaled_code);
        end else begin
          interval_ff <= interval_ff + SLEW_CNT_W_L'(1);
        end
      end
    end
  end

  // products settle before the strobe; offset only pulls the report down
  // host gain to 0.25A per bit
  assign host_prod   = gain_mul(total_current_monitor_pin_sample, host_gain_ff);
  assign cpu_prod    = gain_mul(total_current_monitor_pin_sample, cpu_gain_ff);
  assign host_amps   = host_prod[31:vrref_pkg::GAIN_SHIFT];
  assign offset_amps = 24'(total_current_monitor_pin_offset);
  assign droop_prod  = (IW+8)'(current_sum_node) * (IW+8)'(vrref_pkg::DROOP_NUM);

  // readback register; floors at zero rather than wrapping
  always_ff @(posedge core_clk) begin
    if (srst) begin
      iout_ff <= 16'h0000;
    end else if (total_current_monitor_pin_sample_valid) begin
      iout_ff <= (host_amps > offset_amps) ? 16'(host_amps - offset_amps) : 16'h0000;
    end
  end

  // cpu gain telemetry, saturates at FFh
  always_ff @(posedge core_clk) begin
    if (srst) begin
      telemetry_code_ff <= 8'h00;
    end else if (total_current_monitor_pin_sample_valid) begin
      telemetry_code_ff <= (cpu_prod[31:vrref_pkg::GAIN_SHIFT] > TELE_FULL) ?
                           8'hFF : cpu_prod[vrref_pkg::GAIN_SHIFT +: 8];
    end
  end

  // shed when enabled, settled and current low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_shed_ff <= 1'b0;
    end else begin
      phase_shed_ff <= phase_shed_enable && settled_ff &&
                       (iout_ff < 16'(shed_threshold));
    end
  end

  // droop is 5/32 of summed sense
  // Product is eight bits wider than the sense input, so no wrap before shift
  always_ff @(posedge core_clk) begin
    if (srst) begin
      droop_current_ff <= '0;
    end else begin
      droop_current_ff <= IW'(droop_prod >> vrref_pkg::DROOP_SHIFT);
    end
  end
endmodule

/* File: logic/vrref_pkg.sv */
/*
  Shared constants for the reference, load-line and voltage-change block.
  Assumes a 125 MHz core clock and registers reached by word index.
*/
package vrref_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SLEW_TICK_NS  = 50;
  // Core cycles per 50 ns slew tick, rounded down, at least one
  localparam int unsigned SLEW_TICK_CYC =
    (SLEW_TICK_NS / CLK_PERIOD_NS) < 1 ? 1 : (SLEW_TICK_NS / CLK_PERIOD_NS);
  localparam int unsigned SLEW_EXTRA    = 3;

  localparam logic [7:0] REG_DIV_RATIO  = 8'h29;
  localparam logic [7:0] REG_RAMP_TIME  = 8'h61;
  localparam logic [7:0] REG_IOUT_READ  = 8'h8C;
  localparam logic [7:0] REG_CPU_GAIN   = 8'hAD;
  localparam logic [7:0] REG_HOST_GAIN  = 8'hC5;
  localparam logic [7:0] REG_LL_CONFIG  = 8'hDD;

  localparam int unsigned DIV_SHIFT     = 7;
  localparam int unsigned LL_SEL_BIT    = 12;
  localparam int unsigned LL_CODE_LSB   = 9;
  localparam int unsigned PKT_LL_LSB    = 22;
  localparam int unsigned SLEW_CNT_W    = 11;
  localparam int unsigned GAIN_SHIFT    = 8;
  localparam logic [7:0]  CODE_MAX      = 8'hF8;
  localparam logic [15:0] DIV_RST       = 16'h0080;
  localparam logic [15:0] RAMP_RST      = 16'h0000;
  localparam logic [15:0] GAIN_RST      = 16'h0100;
  localparam logic [15:0] LL_RST        = 16'h0000;
  localparam logic [7:0]  DROOP_NUM     = 8'h05;
  localparam int unsigned DROOP_SHIFT   = 5;

  // Slope in tenths of the base slope, per 3-bit code
  function automatic logic [4:0] slope_tenths(input logic [2:0] code);
    unique case (code)
      3'h0: slope_tenths = 5'h00;
      3'h1: slope_tenths = 5'h06;
      3'h2: slope_tenths = 5'h08;
      3'h3: slope_tenths = 5'h0A;
      3'h4: slope_tenths = 5'h0C;
      3'h5: slope_tenths = 5'h0E;
      3'h6: slope_tenths = 5'h10;
      3'h7: slope_tenths = 5'h12;
    endcase
  endfunction
endpackage

/* File: verification/test_vrref_core.sv */
/* Self-checking bench for vrref_core with the serial master model.
   Assumes the package constants and a 125 MHz core clock. */
`timescale 1ns/1ns
module test_vrref_core;
  logic core_clk, srst, reg_wr, serial_pkt_valid, pmbus_target_wr, platform_power_good, send;
  logic phase_shed_enable, total_current_monitor_pin_sample_valid, voltage_change_done_notice_ff;
  logic phase_shed_ff, settled_ff;
  logic [1:0]  vid_mode;
  logic [2:0]  send_code;
  logic [4:0]  slope_tenths_ff;
  logic [7:0]  reg_addr, serial_target, pmbus_target, parallel_target, shed_threshold;
  logic [7:0]  send_tgt, ref_code_ff, telemetry_code_ff;
  logic [11:0] total_current_monitor_pin_sample, current_sum_node, droop_current_ff;
  logic [15:0] reg_wdata, reg_rdata_ff, total_current_monitor_pin_offset, rd_val;
  logic [24:0] serial_packet;
  int          n_fail, compares, n_done;
  vrref_core dut_u (.core_clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_ff,
    .vid_mode, .serial_target, .serial_pkt_valid, .serial_packet, .pmbus_target,
    .pmbus_target_wr, .parallel_target, .platform_power_good, .phase_shed_enable,
    .shed_threshold, .total_current_monitor_pin_sample, .total_current_monitor_pin_sample_valid, .total_current_monitor_pin_offset, .current_sum_node,
    .ref_code_ff, .slope_tenths_ff, .telemetry_code_ff, .voltage_change_done_notice_ff,
    .phase_shed_ff, .settled_ff, .droop_current_ff);
  vrref_host_model host_u (.core_clk, .send, .tgt(send_tgt), .code(send_code),
    .serial_target, .serial_pkt_valid, .serial_packet);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (voltage_change_done_notice_ff === 1'b1) n_done++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tick(1);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    tick(1);
    reg_addr <= a;
    tick(2);
    rd_val = reg_rdata_ff;
  endtask
  // Bounded wait; a hang shows up as a wrong reference code
  task automatic wait_set();
    tick(4);
    for (int i = 0; i < 5000 && settled_ff !== 1'b1; i++) tick(1);
  endtask
  task automatic pm(input logic [7:0] t);
    tick(1);
    pmbus_target <= t;
    pmbus_target_wr <= 1'b1;
    tick(1);
    pmbus_target_wr <= 1'b0;
  endtask
  task automatic sv(input logic [7:0] t, input logic [2:0] c);
    tick(1);
    send <= 1'b1;
    send_tgt <= t;
    send_code <= c;
    tick(1);
    send <= 1'b0;
    tick(4);
  endtask
  task automatic smp(input logic [11:0] s);
    tick(1);
    total_current_monitor_pin_sample <= s;
    total_current_monitor_pin_sample_valid <= 1'b1;
    tick(1);
    total_current_monitor_pin_sample_valid <= 1'b0;
    tick(2);
  endtask
  task automatic t_regs();
    logic [7:0]  a [5] = '{vrref_pkg::REG_DIV_RATIO, vrref_pkg::REG_RAMP_TIME,
      vrref_pkg::REG_CPU_GAIN, vrref_pkg::REG_HOST_GAIN, vrref_pkg::REG_LL_CONFIG};
    logic [15:0] r [5] = '{vrref_pkg::DIV_RST, vrref_pkg::RAMP_RST, vrref_pkg::GAIN_RST,
      vrref_pkg::GAIN_RST, vrref_pkg::LL_RST};
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      chk("reset value", r[i], rd_val);
      wr(a[i], 16'h0155);
      rd(a[i]);
      chk("readback", 16'h0155, rd_val);
      wr(a[i], r[i]);
    end
    wr(vrref_pkg::REG_IOUT_READ, 16'hFFFF);
    rd(vrref_pkg::REG_IOUT_READ);
    chk("read only", 16'h0000, rd_val);
    rd(8'h00);
    chk("unmapped", 16'h0000, rd_val);
  endtask
  task automatic t_slope();
    for (int c = 0; c < 8; c++) begin
      wr(vrref_pkg::REG_LL_CONFIG, 16'h1000 | (16'(c) << 9));
      tick(2);
      chk("slope", (c == 0) ? 16'h0000 : 16'(c) * 16'h2 + 16'h4, 16'(slope_tenths_ff));
    end
    wr(vrref_pkg::REG_LL_CONFIG, 16'h0000);
    sv(8'h00, 3'h5);
    chk("packet slope", 16'h000E, 16'(slope_tenths_ff));
  endtask
  task automatic t_ramp();
    int g;
    logic [7:0] r;
    wr(vrref_pkg::REG_RAMP_TIME, 16'h0001);
    wr(vrref_pkg::REG_DIV_RATIO, 16'h0040);
    pm(8'h65);
    r = ref_code_ff;
    for (g = 0; g < 200 && ref_code_ff === r; g++) tick(1);
    r = ref_code_ff;
    for (g = 0; g < 200 && ref_code_ff === r; g++) tick(1);
    chk("step gap", 16'(4 * vrref_pkg::SLEW_TICK_CYC), 16'(g));
    wait_set();
    chk("scaled ref", 16'h0032, 16'(ref_code_ff));
    chk("settled", 16'h0001, 16'(settled_ff));
    pm(8'h21);
    wait_set();
    chk("down ref", 16'h0010, 16'(ref_code_ff));
    wr(vrref_pkg::REG_DIV_RATIO, 16'h0000);
    wait_set();
    chk("zero ratio", 16'h0021, 16'(ref_code_ff));
    vid_mode <= 2'h2;
    parallel_target <= 8'h08;
    wait_set();
    chk("parallel ref", 16'h0008, 16'(ref_code_ff));
  endtask
  task automatic t_serial();
    int d;
    vid_mode <= 2'h0;
    sv(8'h40, 3'h0);
    tick(200);
    chk("no power good", 16'h0008, 16'(ref_code_ff));
    platform_power_good <= 1'b1;
    tick(4);
    d = n_done;
    sv(8'h20, 3'h3);
    wait_set();
    chk("serial ref", 16'h0020, 16'(ref_code_ff));
    tick(1);
    chk("done notice", 16'h0001, 16'(n_done - d));
  endtask
  task automatic t_current();
    wr(vrref_pkg::REG_HOST_GAIN, 16'h0200);
    phase_shed_enable <= 1'b1;
    shed_threshold <= 8'h30;
    total_current_monitor_pin_offset <= 16'h0004;
    current_sum_node <= 12'h640;
    smp(12'h100);
    chk("telemetry", 16'h00FF, 16'(telemetry_code_ff));
    chk("droop", 16'h00FA, 16'(droop_current_ff));
    rd(vrref_pkg::REG_IOUT_READ);
    chk("readback", 16'h01FC, rd_val);
    chk("no shed", 16'h0000, 16'(phase_shed_ff));
    smp(12'h010);
    chk("telemetry", 16'h0010, 16'(telemetry_code_ff));
    rd(vrref_pkg::REG_IOUT_READ);
    chk("readback", 16'h001C, rd_val);
    for (int i = 0; i < 50 && phase_shed_ff !== 1'b1; i++) tick(1);
    chk("shed", 16'h0001, 16'(phase_shed_ff));
  endtask
  task automatic test_done();
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {srst, reg_wr, pmbus_target_wr, platform_power_good, send} = 5'h10;
    {phase_shed_enable, total_current_monitor_pin_sample_valid, vid_mode, send_code} = 7'h08;
    {reg_addr, pmbus_target, parallel_target, shed_threshold, send_tgt} = 40'h0;
    {total_current_monitor_pin_sample, current_sum_node, reg_wdata, total_current_monitor_pin_offset} = 56'h0;
    tick(16);
    srst <= 1'b0;
    t_regs();
    t_slope();
    t_ramp();
    t_serial();
    t_current();
    test_done();
  end
  // Runs take about 2200 cycles
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule

/* File: verification/vrref_core_asserts.sv */
/* Checker bound to the vrref_core ports.
   Assumes one-cycle write strobes and the package reset values. */
`timescale 1ns/1ns
module vrref_core_chk #(
  parameter int unsigned IW = 12
) (
  input wire logic          core_clk,
  input wire logic          srst,
  input wire logic          reg_wr,
  input wire logic [7:0]    reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic [15:0]   reg_rdata_ff,
  input wire logic [1:0]    vid_mode,
  input wire logic [IW-1:0] total_current_monitor_pin_sample,
  input wire logic          total_current_monitor_pin_sample_valid,
  input wire logic [IW-1:0] current_sum_node,
  input wire logic [7:0]    ref_code_ff,
  input wire logic [4:0]    slope_tenths_ff,
  input wire logic [7:0]    telemetry_code_ff,
  input wire logic          voltage_change_done_notice_ff,
  input wire logic [IW-1:0] droop_current_ff
);
  logic [15:0]    gain_ff;
  logic [15:0]    ll_ff;
  logic [IW+15:0] prod;
  logic [7:0]     tele;
  assign prod = total_current_monitor_pin_sample * gain_ff;
  // Saturate, never wrap
  assign tele = (|prod[IW+15:16]) ? 8'hFF : prod[15:8];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gain_ff <= vrref_pkg::GAIN_RST;
      ll_ff   <= vrref_pkg::LL_RST;
    end else if (reg_wr && reg_addr == vrref_pkg::REG_CPU_GAIN) begin
      gain_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == vrref_pkg::REG_LL_CONFIG) begin
      ll_ff <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_slope_code: assert property (
    ll_ff[12] && $stable(ll_ff) |-> slope_tenths_ff == ((ll_ff[11:9] == 3'h0) ? 5'h00 :
    5'(ll_ff[11:9]) * 5'h2 + 5'h4)) else $error("slope code wrong");
  chk_tele_scale: assert property (
    $past(total_current_monitor_pin_sample_valid) && !$past(srst) |-> telemetry_code_ff == $past(tele))
    else $error("telemetry code wrong");
  chk_gain_read: assert property (
    $past(reg_addr) == vrref_pkg::REG_CPU_GAIN && !$past(srst) |-> reg_rdata_ff == $past(gain_ff))
    else $error("gain readback wrong");
  chk_droop_ratio: assert property (
    !$past(srst) |-> droop_current_ff ==
    IW'((32'($past(current_sum_node)) * vrref_pkg::DROOP_NUM) >> vrref_pkg::DROOP_SHIFT))
    else $error("droop current wrong");
  chk_ref_span: assert property (ref_code_ff <= vrref_pkg::CODE_MAX)
    else $error("reference above span");
  chk_step_size: assert property (
    !$past(srst) |-> 8'(ref_code_ff - $past(ref_code_ff) + 8'h02) <= 8'h04)
    else $error("reference step too large");
  chk_step_gap: assert property (
    $changed(ref_code_ff) && !$past(srst) |=> $stable(ref_code_ff) [*8] ##1
    $stable(ref_code_ff) [*8]) else $error("reference steps too close");
  chk_done_pulse: assert property (
    voltage_change_done_notice_ff |-> vid_mode == 2'h0 ##1 !voltage_change_done_notice_ff)
    else $error("done notice wrong");
endmodule
bind vrref_core vrref_core_chk #(.IW(IW)) chk_u (.core_clk, .srst, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata_ff, .vid_mode, .total_current_monitor_pin_sample, .total_current_monitor_pin_sample_valid, .current_sum_node,
  .ref_code_ff, .slope_tenths_ff, .telemetry_code_ff, .voltage_change_done_notice_ff,
  .droop_current_ff);

/* File: verification/vrref_host_model.sv */
/* Serial voltage master model: one packet per send pulse.
   Assumes send is driven just after a core_clk edge. */
`timescale 1ns/1ns
module vrref_host_model (
  input  wire logic        core_clk,
  input  wire logic        send,
  input  wire logic [7:0]  tgt,
  input  wire logic [2:0]  code,
  output logic      [7:0]  serial_target = 8'h00,
  output logic             serial_pkt_valid = 1'b0,
  output logic      [24:0] serial_packet = 25'h0000000
);
  // slope code in top bits; idle lines toggle so stale data is never reused
  always @(posedge core_clk) begin
    serial_pkt_valid <= send;
    serial_packet    <= send ? {code, 14'h0000, tgt} : ~serial_packet;
    serial_target    <= send ? tgt : ~serial_target;
  end
endmodule
